// *** serial_port_defs.svh ***
// Constants of the host serial port: offsets, fields, resets, timing.
// Assumes a 100 MHz aclk and a 32-bit AXI4-Lite register bus.
`ifndef SERIAL_PORT_DEFS_SVH
`define SERIAL_PORT_DEFS_SVH

`define SP_CLK_HZ 32'h05f5e100
`define SP_BUF_AW 7
`define SP_BUF_DEPTH 8'h80

// Register byte offsets
`define SP_OFF_BAUD 8'h00
`define SP_OFF_PARITY 8'h04
`define SP_OFF_SILENCE 8'h08
`define SP_OFF_THRESH 8'h0c
`define SP_OFF_MODE 8'h10
`define SP_OFF_FORMAT 8'h14
`define SP_OFF_STATUS 8'h18

// Status fields
`define SP_ST_CTS 8
`define SP_ST_XOFF 9
`define SP_ST_PERR 16
`define SP_ST_FERR 17
`define SP_ST_OVR 18

// Reset values
`define SP_BAUD_DEF 18'h00003
`define SP_DIV_DEF 17'h028b1
`define SP_PARITY_DEF 2'h0
`define SP_SILENCE_DEF 8'h03
`define SP_THRESH_DEF 7'h51
`define SP_MODE_DEF 2'h0
`define SP_FORMAT_DEF 1'h0

// Legal ranges
`define SP_BAUD_CODE_MAX 18'h00008
`define SP_BAUD_LIT_MIN 18'h004b0
`define SP_BAUD_LIT_MAX 18'h3d090
`define SP_THRESH_MIN 7'h07
`define SP_THRESH_MAX 7'h66
`define SP_MODE_MAX 2'h2
`define SP_HYST 8'h10

// Standard rates by code
`define SP_RATE_0 18'h004b0
`define SP_RATE_1 18'h00960
`define SP_RATE_2 18'h012c0
`define SP_RATE_3 18'h02580
`define SP_RATE_4 18'h04b00
`define SP_RATE_5 18'h09600
`define SP_RATE_6 18'h0e100
`define SP_RATE_7 18'h1c200
`define SP_RATE_8 18'h38400

// Characters and frame types
`define SP_XOFF 8'h13
`define SP_XON 8'h11
`define SP_FT_RX 8'h90
`define SP_FT_EXPLICIT 8'h91
`define SP_BITS_BASE 4'ha

`endif

// *** serial_port_pkg.sv ***
// Types of the host serial port: state enums and the state record.
// Assumes serial_port_defs.svh is on the include path.
`include "serial_port_defs.svh"
package serial_port_pkg;
	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_START = 2'b01,
		RX_DATA = 2'b10,
		RX_STOP = 2'b11
	} rx_state_e;

	typedef enum logic {
		TX_IDLE = 1'b0,
		TX_RUN = 1'b1
	} tx_state_e;

	typedef struct packed {
		logic [17:0] baud;
		logic [16:0] div;
		logic [1:0] parity;
		logic [7:0] silence;
		logic [6:0] thresh;
		logic [1:0] mode;
		logic fmt;
		logic rx_s1;
		logic rx_s2;
		rx_state_e rx_st;
		logic [16:0] rx_cnt;
		logic [3:0] rx_bit;
		logic [8:0] rx_shift;
		tx_state_e tx_st;
		logic [16:0] tx_cnt;
		logic [3:0] tx_bit;
		logic [10:0] tx_shift;
		logic txd;
		logic xoff;
		logic send_xoff;
		logic send_xon;
		logic [`SP_BUF_AW-1:0] wr_ptr;
		logic [`SP_BUF_AW-1:0] rd_ptr;
		logic [7:0] count;
		logic [16:0] sil_cnt;
		logic [11:0] sil_bits;
		logic sending;
		logic [7:0] pkt_left;
		logic perr;
		logic ferr;
		logic ovr;
		logic aw_got;
		logic [7:0] aw_addr;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} state_s;
endpackage

// *** host_serial_port_config.sv ***
// Host-facing asynchronous serial port with AXI4-Lite configuration.
// Assumes rxd arrives from outside aclk; pkt_ready from aclk logic.
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`include "serial_port_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module host_serial_port_config (
	// Clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// AXI4-Lite write
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// AXI4-Lite read
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	input wire logic [2:0] arprot,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// Serial pins
	input wire logic rxd,
	output logic txd,
	output logic cts_n,
	// Outgoing data to the radio
	output logic pkt_valid,
	input wire logic pkt_ready,
	output logic [7:0] pkt_data,
	output logic pkt_last,
	// Mode outputs
	output logic api_mode,
	output logic api_escape,
	output logic [7:0] rx_frame_type
);
	serial_port_pkg::state_s r;
	serial_port_pkg::state_s next_r;
	logic [7:0] buf_mem [0:`SP_BUF_DEPTH-1];
	logic push;

	function automatic logic [17:0] std_rate(input logic [3:0] code);
		logic [17:0] v;
		v = `SP_RATE_3;
		unique case (code)
			4'h0: v = `SP_RATE_0;
			4'h1: v = `SP_RATE_1;
			4'h2: v = `SP_RATE_2;
			4'h3: v = `SP_RATE_3;
			4'h4: v = `SP_RATE_4;
			4'h5: v = `SP_RATE_5;
			4'h6: v = `SP_RATE_6;
			4'h7: v = `SP_RATE_7;
			4'h8: v = `SP_RATE_8;
			default: v = `SP_RATE_3;
		endcase
		return v;
	endfunction

	// Rounded division of the clock by a rate or a divisor
	function automatic logic [31:0] near_div(input logic [31:0] d);
		return (`SP_CLK_HZ + (d >> 1)) / d;
	endfunction

	function automatic logic par_bit(input logic [1:0] p,
		input logic [7:0] d);
		logic b;
		b = 1'b0;
		unique case (p)
			2'h1: b = ^d;
			2'h2: b = ~^d;
			2'h3: b = 1'b1;
			default: b = 1'b0;
		endcase
		return b;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] s);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				m[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return m;
	endfunction

	logic [3:0] char_bits;
	logic [11:0] sil_target;
	logic [31:0] status;
	logic [31:0] wval;
	logic [17:0] req_rate;
	logic [31:0] new_div;
	logic [31:0] held_rate;
	logic pop;

	always_comb begin
		char_bits = `SP_BITS_BASE + {3'h0, r.parity != 2'h0};
		sil_target = 12'({4'h0, r.silence} * {8'h0, char_bits});
		status = 32'h0;
		status[7:0] = r.count;
		status[`SP_ST_CTS] = r.xoff;
		status[`SP_ST_XOFF] = r.xoff;
		status[`SP_ST_PERR] = r.perr;
		status[`SP_ST_FERR] = r.ferr;
		status[`SP_ST_OVR] = r.ovr;
	end

	always_comb begin
		next_r = r;
		push = 1'b0;
		pop = pkt_valid && pkt_ready;
		wval = 32'h0;
		req_rate = 18'h0;
		new_div = 32'h0;
		held_rate = 32'h0;

		// Receiver
		next_r.rx_s1 = rxd;
		next_r.rx_s2 = r.rx_s1;
		if (r.rx_cnt != 17'h0) begin
			next_r.rx_cnt = r.rx_cnt - 17'h1;
		end
		unique case (r.rx_st)
			serial_port_pkg::RX_IDLE: begin
				if (!r.rx_s2) begin
					next_r.rx_st = serial_port_pkg::RX_START;
					next_r.rx_cnt = r.div >> 1;
				end
			end
			serial_port_pkg::RX_START: begin
				if (r.rx_cnt == 17'h0) begin
					next_r.rx_st = r.rx_s2 ? serial_port_pkg::RX_IDLE :
						serial_port_pkg::RX_DATA;
					next_r.rx_cnt = r.div - 17'h1;
					next_r.rx_bit = 4'h0;
				end
			end
			serial_port_pkg::RX_DATA: begin
				if (r.rx_cnt == 17'h0) begin
					next_r.rx_shift = {r.rx_s2, r.rx_shift[8:1]};
					next_r.rx_bit = r.rx_bit + 4'h1;
					next_r.rx_cnt = r.div - 17'h1;
					if (r.rx_bit == char_bits - 4'h3) begin
						next_r.rx_st = serial_port_pkg::RX_STOP;
					end
				end
			end
			serial_port_pkg::RX_STOP: begin
				if (r.rx_cnt == 17'h0) begin
					next_r.rx_st = serial_port_pkg::RX_IDLE;
					if (!r.rx_s2) begin
						next_r.ferr = 1'b1;
					end else if (r.count == `SP_BUF_DEPTH) begin
						next_r.ovr = 1'b1;
					end else begin
						push = 1'b1;
					end
					if (r.parity != 2'h0 && r.rx_shift[8] !=
						par_bit(r.parity, r.rx_shift[7:0])) begin
						next_r.perr = 1'b1;
					end
				end
			end
		endcase

		// Line silence, counted in bit times
		if (r.rx_st != serial_port_pkg::RX_IDLE || !r.rx_s2) begin
			next_r.sil_cnt = r.div - 17'h1;
			next_r.sil_bits = 12'h0;
		end else if (r.sil_cnt != 17'h0) begin
			next_r.sil_cnt = r.sil_cnt - 17'h1;
		end else if (r.sil_bits != 12'hfff) begin
			next_r.sil_bits = r.sil_bits + 12'h1;
			next_r.sil_cnt = r.div - 17'h1;
		end

		// Buffer pointers and packet release
		if (push) begin
			next_r.wr_ptr = r.wr_ptr + `SP_BUF_AW'(1);
		end
		if (pop) begin
			next_r.rd_ptr = r.rd_ptr + `SP_BUF_AW'(1);
			next_r.pkt_left = r.pkt_left - 8'h1;
			if (r.pkt_left == 8'h1) begin
				next_r.sending = 1'b0;
			end
		end
		next_r.count = r.count + {7'h0, push} - {7'h0, pop};
		if (!r.sending && r.count != 8'h0) begin
			if (r.mode != 2'h0) begin
				next_r.sending = 1'b1;
				next_r.pkt_left = 8'h1;
			end else if (r.silence == 8'h0) begin
				next_r.sending = 1'b1;
				next_r.pkt_left = 8'h1;
			end else if (r.sil_bits >= sil_target) begin
				next_r.sending = 1'b1;
				next_r.pkt_left = r.count;
			end
		end

		// Flow control with hysteresis
		if (!r.xoff && r.count >= {1'b0, r.thresh}) begin
			next_r.xoff = 1'b1;
			next_r.send_xoff = 1'b1;
			next_r.send_xon = 1'b0;
		end else if (r.xoff && r.count + `SP_HYST < {1'b0, r.thresh}) begin
			next_r.xoff = 1'b0;
			next_r.send_xon = 1'b1;
			next_r.send_xoff = 1'b0;
		end

		// Transmitter for flow characters
		unique case (r.tx_st)
			serial_port_pkg::TX_IDLE: begin
				next_r.txd = 1'b1;
				if (r.send_xoff || r.send_xon) begin
					wval[7:0] = r.send_xoff ? `SP_XOFF : `SP_XON;
					next_r.tx_shift = {1'b1, par_bit(r.parity, wval[7:0]),
						wval[7:0], 1'b0};
					if (r.parity == 2'h0) begin
						next_r.tx_shift[9] = 1'b1;
					end
					next_r.send_xoff = 1'b0;
					next_r.send_xon = 1'b0;
					next_r.tx_bit = 4'h0;
					next_r.tx_cnt = r.div - 17'h1;
					next_r.txd = 1'b0;
					next_r.tx_st = serial_port_pkg::TX_RUN;
				end
			end
			serial_port_pkg::TX_RUN: begin
				if (r.tx_cnt != 17'h0) begin
					next_r.tx_cnt = r.tx_cnt - 17'h1;
				end else if (r.tx_bit == char_bits - 4'h1) begin
					next_r.tx_st = serial_port_pkg::TX_IDLE;
					next_r.txd = 1'b1;
				end else begin
					next_r.tx_shift = {1'b1, r.tx_shift[10:1]};
					next_r.txd = r.tx_shift[1];
					next_r.tx_bit = r.tx_bit + 4'h1;
					next_r.tx_cnt = r.div - 17'h1;
				end
			end
		endcase

		// AXI4-Lite write channel
		if (awvalid && awready) begin
			next_r.aw_got = 1'b1;
			next_r.aw_addr = awaddr;
		end
		if (wvalid && wready) begin
			next_r.w_got = 1'b1;
			next_r.w_data = wdata;
			next_r.w_strb = wstrb;
		end
		if (bvalid && bready) begin
			next_r.bvalid = 1'b0;
		end
		if (r.aw_got && r.w_got && !r.bvalid) begin
			next_r.aw_got = 1'b0;
			next_r.w_got = 1'b0;
			next_r.bvalid = 1'b1;
			next_r.bresp = 2'b00;
			unique case (r.aw_addr)
				`SP_OFF_BAUD: begin
					wval = merge({14'h0, r.baud}, r.w_data, r.w_strb);
					req_rate = (wval <= 32'(`SP_BAUD_CODE_MAX)) ?
						std_rate(wval[3:0]) : wval[17:0];
					new_div = near_div({14'h0, req_rate});
					held_rate = near_div(new_div);
					if (wval <= 32'(`SP_BAUD_CODE_MAX)) begin
						next_r.baud = wval[17:0];
						next_r.div = new_div[16:0];
					end else if (wval >= 32'(`SP_BAUD_LIT_MIN) &&
						wval <= 32'(`SP_BAUD_LIT_MAX)) begin
						next_r.baud = held_rate[17:0];
						next_r.div = new_div[16:0];
					end
				end
				`SP_OFF_PARITY: begin
					wval = merge({30'h0, r.parity}, r.w_data, r.w_strb);
					if (wval[31:2] == 30'h0) begin
						next_r.parity = wval[1:0];
					end
				end
				`SP_OFF_SILENCE: begin
					wval = merge({24'h0, r.silence}, r.w_data, r.w_strb);
					next_r.silence = wval[7:0];
				end
				`SP_OFF_THRESH: begin
					wval = merge({25'h0, r.thresh}, r.w_data, r.w_strb);
					if (wval >= 32'(`SP_THRESH_MIN) &&
						wval <= 32'(`SP_THRESH_MAX)) begin
						next_r.thresh = wval[6:0];
					end
				end
				`SP_OFF_MODE: begin
					wval = merge({30'h0, r.mode}, r.w_data, r.w_strb);
					if (wval <= 32'(`SP_MODE_MAX)) begin
						next_r.mode = wval[1:0];
					end
				end
				`SP_OFF_FORMAT: begin
					wval = merge({31'h0, r.fmt}, r.w_data, r.w_strb);
					if (wval[31:1] == 31'h0) begin
						next_r.fmt = wval[0];
					end
				end
				`SP_OFF_STATUS: begin
					wval = r.w_data & {{8{r.w_strb[3]}}, {8{r.w_strb[2]}},
						{8{r.w_strb[1]}}, {8{r.w_strb[0]}}};
					next_r.perr = next_r.perr & ~wval[`SP_ST_PERR];
					next_r.ferr = next_r.ferr & ~wval[`SP_ST_FERR];
					next_r.ovr = next_r.ovr & ~wval[`SP_ST_OVR];
					if (r.rx_st == serial_port_pkg::RX_STOP &&
						r.rx_cnt == 17'h0) begin
						next_r.perr = next_r.perr | (r.parity != 2'h0 &&
							r.rx_shift[8] != par_bit(r.parity, r.rx_shift[7:0]));
						next_r.ferr = next_r.ferr | !r.rx_s2;
						next_r.ovr = next_r.ovr | (r.rx_s2 &&
							r.count == `SP_BUF_DEPTH);
					end
				end
				default: next_r.bresp = 2'b10;
			endcase
		end

		// AXI4-Lite read channel
		if (rvalid && rready) begin
			next_r.rvalid = 1'b0;
		end
		if (arvalid && arready) begin
			next_r.rvalid = 1'b1;
			next_r.rresp = 2'b00;
			unique case (araddr)
				`SP_OFF_BAUD: next_r.rdata = {14'h0, r.baud};
				`SP_OFF_PARITY: next_r.rdata = {30'h0, r.parity};
				`SP_OFF_SILENCE: next_r.rdata = {24'h0, r.silence};
				`SP_OFF_THRESH: next_r.rdata = {25'h0, r.thresh};
				`SP_OFF_MODE: next_r.rdata = {30'h0, r.mode};
				`SP_OFF_FORMAT: next_r.rdata = {31'h0, r.fmt};
				`SP_OFF_STATUS: next_r.rdata = status;
				default: begin
					next_r.rdata = 32'h0;
					next_r.rresp = 2'b10;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r <= '0;
			r.baud <= `SP_BAUD_DEF;
			r.div <= `SP_DIV_DEF;
			r.parity <= `SP_PARITY_DEF;
			r.silence <= `SP_SILENCE_DEF;
			r.thresh <= `SP_THRESH_DEF;
			r.mode <= `SP_MODE_DEF;
			r.fmt <= `SP_FORMAT_DEF;
			r.rx_s1 <= 1'b1;
			r.rx_s2 <= 1'b1;
			r.txd <= 1'b1;
			r.tx_shift <= 11'h7ff;
		end else if (ce) begin
			r <= next_r;
		end
	end

	always_ff @(posedge aclk) begin
		if (ce && push) begin
			buf_mem[r.wr_ptr] <= (r.parity == 2'h0) ? r.rx_shift[8:1] :
				r.rx_shift[7:0];
		end
	end

	assign awready = !r.aw_got && !r.bvalid;
	assign wready = !r.w_got && !r.bvalid;
	assign bvalid = r.bvalid;
	assign bresp = r.bresp;
	assign arready = !r.rvalid;
	assign rvalid = r.rvalid;
	assign rdata = r.rdata;
	assign rresp = r.rresp;
	assign txd = r.txd;
	assign cts_n = r.xoff;
	assign pkt_valid = r.sending;
	assign pkt_data = buf_mem[r.rd_ptr];
	assign pkt_last = r.pkt_left == 8'h1;
	assign api_mode = r.mode != 2'h0;
	assign api_escape = r.mode == 2'h2;
	assign rx_frame_type = r.fmt ? `SP_FT_EXPLICIT : `SP_FT_RX;
endmodule
`default_nettype wire

// *** host_uart_model.sv ***
// Host model on the serial link: sends characters, collects txd bytes.
// Assumes aclk at 100 MHz and a divisor in aclk cycles per bit.
`timescale 1ns/1ps
`default_nettype none
module host_uart_model (
	// Clock
	input wire logic aclk,
	// Serial lines
	output logic rxd,
	input wire logic txd
);
	int div = 400;
	logic [7:0] r;
	logic [7:0] got_q[$];
	initial rxd = 1'b1;
	task automatic send(input logic [7:0] b, input int par = 0,
		input bit flip = 1'b0);
		logic [10:0] f;
		int nb;
		f = {2'b11, b, 1'b0};
		nb = 10;
		if (par != 0) begin
			f[9] = (par == 3 ? 1'b1 : par == 1 ? ^b : ~^b) ^ flip;
			nb = 11;
		end
		for (int i = 0; i < nb; i++) begin
			@(posedge aclk);
			rxd <= f[i];
			repeat (div - 1) @(posedge aclk);
		end
	endtask
	always @(negedge txd) begin
		repeat (div / 2) @(posedge aclk);
		for (int i = 0; i < 8; i++) begin
			repeat (div) @(posedge aclk);
			r[i] = txd;
		end
		repeat (div) @(posedge aclk);
		if (txd === 1'b1) got_q.push_back(r);
	end
endmodule
`default_nettype wire

// *** host_serial_port_chk.sv ***
// Checker of the serial port: bus answers, packet stream, flow pins.
// Assumes it is bound onto host_serial_port_config.
`timescale 1ns/1ps
`default_nettype none
module host_serial_port_chk (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// Register bus
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	// Serial and packet side
	input wire logic txd,
	input wire logic cts_n,
	input wire logic pkt_valid,
	input wire logic pkt_ready,
	input wire logic [7:0] pkt_data,
	input wire logic pkt_last,
	input wire logic api_mode,
	input wire logic api_escape,
	input wire logic [7:0] rx_frame_type
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	write_answer_a: assert property (
		ce && awvalid && awready && wvalid && wready |-> ##2 bvalid)
		else $error("write not answered");
	write_hold_a: assert property (bvalid && !bready |=> bvalid)
		else $error("write response dropped");
	read_answer_a: assert property (ce && arvalid && arready |=> rvalid)
		else $error("read not answered");
	read_hold_a: assert property (
		rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data not held");
	escape_api_a: assert property (api_escape |-> api_mode)
		else $error("escape without api mode");
	frame_type_a: assert property (
		rx_frame_type == 8'h90 || rx_frame_type == 8'h91)
		else $error("bad frame type");
	pkt_hold_a: assert property (pkt_valid && !pkt_ready |=>
		pkt_valid && $stable(pkt_data) && $stable(pkt_last))
		else $error("packet byte not held");
	api_single_a: assert property (api_mode && pkt_valid |-> pkt_last)
		else $error("api byte not single");
	cts_rise_a: assert property (
		$rose(cts_n) |-> !$past(pkt_valid) || !$past(pkt_ready))
		else $error("cts dropped on a pop");
	start_bit_a: assert property ($fell(txd) |-> !txd [*8])
		else $error("start bit too short");
	reset_out_a: assert property (disable iff (1'b0)
		!aresetn && ce |=> txd && !cts_n && !pkt_valid && !bvalid)
		else $error("bad reset outputs");
endmodule
bind host_serial_port_config host_serial_port_chk i_chk (.aclk, .aresetn,
	.ce, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready, .arvalid,
	.arready, .rvalid, .rready, .rdata, .txd, .cts_n, .pkt_valid, .pkt_ready,
	.pkt_data, .pkt_last, .api_mode, .api_escape, .rx_frame_type);
`default_nettype wire

// *** host_serial_port_config_test.sv ***
// Bench of the serial port: register tasks, host model, packet model.
// Assumes the checker is bound and the host model drives rxd.
`include "serial_port_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module host_serial_port_config_test;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, pkt_ready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, pkt_data, rx_frame_type;
	logic [31:0] wdata = 32'h0, rdata, b, d;
	logic [31:0] seed = 32'h0000005d;
	logic [1:0] bresp, rresp, resp;
	logic awready, wready, bvalid, arready, rvalid, rxd, txd, cts_n;
	logic pkt_valid, pkt_last, api_mode, api_escape;
	logic [8:0] exp_q[$];
	int err_count = 0, check_count = 0, cyc = 0, n, m;
	always #5 aclk = ~aclk;
	host_serial_port_config i_dut (.aclk, .aresetn, .ce(1'b1),
		.awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata,
		.wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
		.arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .rxd, .txd, .cts_n,
		.pkt_valid, .pkt_ready, .pkt_data, .pkt_last, .api_mode, .api_escape,
		.rx_frame_type);
	host_uart_model i_host (.aclk, .rxd, .txd);
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input string s, input logic [31:0] e, g);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] x);
		@(posedge aclk);
		awaddr <= a;
		wdata <= x;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		resp = bresp;
	endtask
	task automatic rc(input string s, input logic [7:0] a, input logic [31:0] e);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		resp = rresp;
		chk(s, e, rdata);
	endtask
	task automatic drain(input int k);
		n = 0;
		pkt_ready <= 1'b1;
		while (n < k) begin
			@(posedge aclk);
			if (pkt_valid && pkt_ready) n++;
			if (n == k) pkt_ready <= 1'b0;
		end
	endtask
	// Packet model: every popped byte against the expected queue
	always @(posedge aclk)
		if (pkt_valid && pkt_ready)
			chk("packet byte", exp_q.pop_front(), {pkt_last, pkt_data});
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 110000) begin
			err_count++;
			close_out();
		end
	end
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rc("baud", `SP_OFF_BAUD, 32'h3);
		rc("parity", `SP_OFF_PARITY, 32'h0);
		rc("silence", `SP_OFF_SILENCE, 32'h3);
		rc("threshold", `SP_OFF_THRESH, 32'h51);
		rc("mode", `SP_OFF_MODE, 32'h0);
		rc("format", `SP_OFF_FORMAT, 32'h0);
		$display("defaults done");
		for (int i = 0; i < 10; i++) begin
			wr(`SP_OFF_BAUD, i);
			rc("baud code", `SP_OFF_BAUD, i < 9 ? i : 8);
		end
		for (int i = 0; i < 8; i++) begin
			b = i == 6 ? 32'h4b0 : i == 7 ? 32'h3d090 : 32'h4b0 + rnd() % 32'h3cbe1;
			d = (`SP_CLK_HZ + b / 2) / b;
			wr(`SP_OFF_BAUD, b);
			rc("baud rate", `SP_OFF_BAUD, (`SP_CLK_HZ + d / 2) / d);
		end
		wr(`SP_OFF_BAUD, 32'h3d091);
		rc("baud kept", `SP_OFF_BAUD, 32'h3d090);
		for (int i = 0; i < 5; i++) begin
			wr(`SP_OFF_PARITY, i);
			rc("parity", `SP_OFF_PARITY, i < 4 ? i : 3);
		end
		wr(`SP_OFF_PARITY, 32'h0);
		for (int i = 0; i < 5; i++) begin
			m = i == 3 ? 2 : i % 4;
			wr(`SP_OFF_MODE, i % 4);
			rc("mode", `SP_OFF_MODE, m);
			chk("api flags", m == 2 ? 3 : m, {api_escape, api_mode});
		end
		wr(`SP_OFF_MODE, 32'h0);
		for (int i = 0; i < 3; i++) begin
			wr(`SP_OFF_FORMAT, i);
			chk("frame type", i ? 32'h91 : 32'h90, rx_frame_type);
		end
		wr(8'h1c, 32'h1);
		chk("unmapped write", 32'h2, resp);
		rc("unmapped read", 8'h1c, 32'h0);
		chk("unmapped resp", 32'h2, resp);
		$display("registers done");
		wr(`SP_OFF_SILENCE, 32'h0);
		wr(`SP_OFF_PARITY, 32'h2);
		pkt_ready <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			b = rnd();
			exp_q.push_back({1'b1, b[7:0]});
			i_host.send(b[7:0], 2, i);
			repeat (20) @(posedge aclk);
			chk("forwarded", 32'h0, exp_q.size());
			rc("parity flag", `SP_OFF_STATUS, i << 16);
		end
		wr(`SP_OFF_STATUS, 32'h00010000);
		rc("flag cleared", `SP_OFF_STATUS, 32'h0);
		wr(`SP_OFF_PARITY, 32'h0);
		$display("silence zero done");
		wr(`SP_OFF_SILENCE, 32'h1);
		for (int i = 0; i < 3; i++) begin
			b = rnd();
			exp_q.push_back({i == 2, b[7:0]});
			i_host.send(b[7:0]);
		end
		repeat (3000) @(posedge aclk);
		chk("held packet", 32'h3, exp_q.size());
		repeat (2000) @(posedge aclk);
		chk("sent packet", 32'h0, exp_q.size());
		$display("silence one done");
		pkt_ready <= 1'b0;
		wr(`SP_OFF_MODE, 32'h1);
		wr(`SP_OFF_THRESH, 32'h11);
		for (int i = 0; i < 17; i++) begin
			b = i ? rnd() : 32'h7e;
			exp_q.push_back({1'b1, b[7:0]});
			chk("cts below", 32'h0, cts_n);
			i_host.send(b[7:0]);
		end
		repeat (2) @(posedge aclk);
		chk("cts at threshold", 32'h1, cts_n);
		while (i_host.got_q.size() == 0) @(posedge aclk);
		chk("stop char", 32'h13, i_host.got_q.pop_front());
		drain(16);
		repeat (20) @(posedge aclk);
		chk("cts in band", 32'h1, cts_n);
		drain(1);
		repeat (3) @(posedge aclk);
		chk("cts released", 32'h0, cts_n);
		while (i_host.got_q.size() == 0) @(posedge aclk);
		chk("resume char", 32'h11, i_host.got_q.pop_front());
		chk("left over", 32'h0, exp_q.size());
		$display("flow done");
		close_out();
	end
endmodule
`default_nettype wire
